// ---- hw/rsseq_top.sv ----
// reset sequencer, cause flags, recovery counter and watchdog prescaler
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rsseq_top
  import rsseq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic osc_ref_clock_i,
  input wire logic power_on_pulse_i,
  input wire logic low_supply_i,
  input wire logic wd_req_i,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_o,
  input wire logic bad_opcode_i,
  input wire logic stop_exec_i,
  input wire logic wait_exec_i,
  input wire logic stop_enable_i,
  input wire logic short_stop_recovery_i,
  input wire logic fetch_i,
  input wire logic unmapped_i,
  input wire logic wake_i,
  input wire logic monitor_mode_i,
  input wire logic break_state_i,
  input wire logic hv_reset_pin_i,
  input wire logic hv_irq_pin_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic internal_reset_o,
  output logic cpu_clk_en_o,
  output logic mod_clk_en_o,
  output logic [15:0] reset_vector_o
);
  // clocking scheme:
  // everything runs on clk_i; the reference oscillator is only sampled.
  // a falling reference edge becomes a one-cycle enable, ref_tick.
  // the bus clock must be well above twice the reference rate,
  // otherwise reference edges are lost and every delay stretches.
  // asynchronous levels (power, supply, watchdog, pin) pass two flops.
  // cpu-side pulses come from the same clock and are used directly.
  // the synchronisers carry no reset: their contents are overwritten
  // within two cycles, well inside the minimum reset hold.
  // the edge detector may see one false edge while reset is held only.
  // synchronisers for the reference, pin, watchdog, power and supply levels
  logic [1:0] s_ref, s_pin, s_wd, s_por, s_lv;
  logic ref_q;
  always_ff @(posedge clk_i) begin
    s_ref <= {s_ref[0], osc_ref_clock_i};
    s_wd <= {s_wd[0], wd_req_i};
    s_por <= {s_por[0], power_on_pulse_i};
    s_lv <= {s_lv[0], low_supply_i};
    ref_q <= s_ref[1];
  end

  always_ff @(posedge clk_i) begin
    s_pin <= {s_pin[0], reset_pin_i};
  end

  // falling reference edge as a one-cycle enable
  logic ref_tick;
  assign ref_tick = ref_q & ~s_ref[1];

  rsseq_state_t state;
  logic [RSSEQ_CNT_W-1:0] cnt;
  logic [12:0] seq_cnt;
  logic [12:0] pin_low_cnt;
  logic [RSSEQ_WD_W-1:0] wd_cnt;
  logic [7:0] cause;
  logic long_rst, stop_short, wd_seen, ext_hold, pin_flag_pend;
  logic pin_low;
  assign pin_low = ~s_pin[1];

  // watchdog disable is purely combinational on high-voltage pins
  logic wd_dis;
  assign wd_dis = (monitor_mode_i & (hv_reset_pin_i | hv_irq_pin_i)) |
                  (break_state_i & hv_reset_pin_i);

  // asynchronous watchdog request latched after synchroniser
  logic wd_ev;
  assign wd_ev = (s_wd[1] | wd_seen) & ~wd_dis;

  // internal source events, only honoured while running
  logic op_ev, ad_ev, svc_wr, run;
  assign run = (state == RSSEQ_RUN);
  assign op_ev = run & (bad_opcode_i | (stop_exec_i & ~stop_enable_i));
  // only opcode fetches from unmapped space count
  assign ad_ev = run & fetch_i & unmapped_i;
  assign svc_wr = wr_i & (addr_i == RSSEQ_WD_SVC_ADDR);

  logic wd_ovf;
  // watchdog overflows at all-ones plus a prescaler overflow
  assign wd_ovf = ref_tick & (&cnt) & (&wd_cnt) & ~wd_dis;

  // sticky watchdog request until the sequence takes it
  always_ff @(posedge clk_i) begin
    if (rst_i | (state == RSSEQ_PIN_LOW))
      wd_seen <= 1'b0;
    else if (s_wd[1] | wd_ovf)
      wd_seen <= 1'b1;
  end

  // sequence outline:
  // osc_wait counts the long settling delay with the pin pulled low,
  // pin_low keeps the pin pulled for the short reset phase,
  // internal_reset_hold keeps only the internal reset for a further phase,
  // run is normal operation, where internal reset sources are taken,
  // stopped holds the counter clear until a wake event or a low pin,
  // stop_rec times the wake delay before the core clocks return.
  // power and supply events restart the long count from any state,
  // so a supply dip during a short sequence still gets full settling.
  // seq_cnt is separate from the recovery counter so that a service
  // write cannot shorten a running reset phase.
  // opcode and address events outside run are ignored; a watchdog request after the pin-low phase waits in wd_seen for run.
  // main sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RSSEQ_OSC_WAIT;
      seq_cnt <= '0;
      long_rst <= 1'b1;
      stop_short <= 1'b0;
    end else if (s_por[1] | s_lv[1]) begin
      // long count with pin forced low
      state <= RSSEQ_OSC_WAIT;
      seq_cnt <= '0;
      long_rst <= 1'b1;
    end else begin
      unique case (state)
        RSSEQ_RUN: begin
          seq_cnt <= '0;
          // internal sources start the pin-low phase
          if (op_ev | ad_ev | wd_ev) begin
            state <= RSSEQ_PIN_LOW;
            long_rst <= 1'b0;
          end else if (stop_exec_i & stop_enable_i)
            state <= RSSEQ_STOPPED;
        end
        RSSEQ_OSC_WAIT: if (ref_tick) begin
          if (seq_cnt == 13'(RSSEQ_POR_CYC - 1)) begin
            seq_cnt <= '0;
            state <= RSSEQ_PIN_LOW;
          end else
            seq_cnt <= seq_cnt + 13'd1;
        end
        RSSEQ_PIN_LOW: if (ref_tick) begin
          if (seq_cnt == 13'(RSSEQ_PIN_CYC - 1)) begin
            seq_cnt <= '0;
            state <= RSSEQ_INTERNAL_RESET_HOLD;
          end else
            seq_cnt <= seq_cnt + 13'd1;
        end
        RSSEQ_INTERNAL_RESET_HOLD: if (ref_tick) begin
          if (seq_cnt == 13'(RSSEQ_INTERNAL_RESET_CYC - 1)) begin
            seq_cnt <= '0;
            long_rst <= 1'b0;
            state <= RSSEQ_RUN;
          end else
            seq_cnt <= seq_cnt + 13'd1;
        end
        RSSEQ_STOPPED: begin
          seq_cnt <= '0;
          if (wake_i | pin_low) begin
            stop_short <= short_stop_recovery_i;
            state <= RSSEQ_STOP_REC;
          end
        end
        RSSEQ_STOP_REC: if (ref_tick) begin
          if (seq_cnt == (stop_short ? 13'(RSSEQ_STOP_SHORT - 1) :
                                       13'(RSSEQ_STOP_LONG - 1))) begin
            seq_cnt <= '0;
            state <= RSSEQ_RUN;
          end else
            seq_cnt <= seq_cnt + 13'd1;
        end
      endcase
    end
  end

  // recovery counter notes:
  // the counter is free running after every reset phase and doubles
  // as the watchdog prescaler, so its wrap clocks the watchdog count.
  // a service write keeps only the low bits, which guarantees that the
  // next wrap is at least the counter span minus the low-bit span away.
  // an external pin reset leaves it alone, but the watchdog count is cleared
  // while internal reset follows a low pin, so a noisy pin can hold it off.
  // while stopped it is held clear and it restarts with the wake delay.
  // internal reset sources clear it at the moment they are taken.
  // recovery counter with watchdog prescale
  always_ff @(posedge clk_i) begin
    // internal resets clear it; the external pin does not
    if (rst_i | s_por[1] | s_lv[1] | (run & (op_ev | ad_ev | wd_ev)))
      cnt <= '0;
    else if (state == RSSEQ_STOPPED)
      cnt <= '0;
    else if (svc_wr)
      cnt <= {{(RSSEQ_CNT_W-RSSEQ_SVC_LO){1'b0}}, cnt[RSSEQ_SVC_LO-1:0]};
    // stepped by the reference clock during recovery too
    else if (ref_tick)
      cnt <= cnt + 13'd1;
  end

  // watchdog counter, clocked by recovery counter overflow
  always_ff @(posedge clk_i) begin
    if (rst_i | internal_reset_o | svc_wr | wd_dis)
      wd_cnt <= '0;
    else if (ref_tick & (&cnt) & run)
      wd_cnt <= wd_cnt + 8'd1;
  end

  // pin flag notes:
  // only lows that the device itself does not drive are measured,
  // so our own pulse never sets the pin flag.
  // the count saturates, so a pin held low for a very long time
  // cannot wrap and drop below the threshold again.
  // the threshold is the longer one while a power or supply sequence
  // is still marked active, since the pin is low for that whole time.
  // a short glitch below the threshold halts the core but sets no flag.
  // measure external low time in reference cycles
  always_ff @(posedge clk_i) begin
    if (rst_i | ~pin_low | reset_pin_oe_o)
      pin_low_cnt <= '0;
    else if (ref_tick & ~(&pin_low_cnt))
      pin_low_cnt <= pin_low_cnt + 13'd1;
  end
  assign pin_flag_pend = ~reset_pin_oe_o & pin_low &
    (pin_low_cnt >= (long_rst ? 13'(RSSEQ_PIN_MIN_POR) : 13'(RSSEQ_PIN_MIN)));

  // external low halts the core while held
  always_ff @(posedge clk_i) begin
    if (rst_i)
      ext_hold <= 1'b0;
    else
      ext_hold <= pin_low & ~reset_pin_oe_o;
  end

  // cause flag notes:
  // flags are sticky and only a power-on event clears them,
  // so software sees every cause since the last power-up.
  // the power-on value has only the power-on flag set.
  // bits 2 and 0 are forced to zero every cycle.
  // an event in the same cycle as a read shows up on the next read,
  // because read data comes from the flag value before the edge.
  // cause flags, set wins; read does not clear
  always_ff @(posedge clk_i) begin
    if (rst_i | s_por[1])
      cause <= RSSEQ_CAUSE_RST;
    else begin
      if (pin_flag_pend)
        cause[RSSEQ_B_PIN] <= 1'b1;
      if (run & wd_ev)
        cause[RSSEQ_B_WD] <= 1'b1;
      if (op_ev)
        cause[RSSEQ_B_OP] <= 1'b1;
      if (ad_ev)
        cause[RSSEQ_B_AD] <= 1'b1;
      if (s_lv[1])
        cause[RSSEQ_B_LV] <= 1'b1;
      cause[2] <= 1'b0;
      cause[0] <= 1'b0;
    end
  end

  // register read, data one cycle after strobe
  always_ff @(posedge clk_i) begin
    if (rst_i)
      rdata_o <= '0;
    else if (rd_i & (addr_i == RSSEQ_CAUSE_ADDR))
      rdata_o <= cause;
    else
      rdata_o <= '0;
  end

  // output notes:
  // every output is registered, so outputs trail the state by a cycle.
  // the pin data is a constant low and only the enable moves,
  // which gives the open-drain behaviour with an outside pull-up.
  // internal reset also follows an outside low on the pin, halting
  // the core for as long as the pin is held.
  // cpu clocks stop in wait mode; module clocks stay on in wait mode.
  // both clock enables stay low through the long count and the stop.
  // the vector pair follows the monitor mode level one cycle later.
  // outputs from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_pin_o <= 1'b0;
      reset_pin_oe_o <= 1'b1;
      internal_reset_o <= 1'b1;
      cpu_clk_en_o <= 1'b0;
      mod_clk_en_o <= 1'b0;
      reset_vector_o <= RSSEQ_VEC_USER;
    end else begin
      reset_pin_o <= 1'b0;
      // pin driven during long count and pin-low phase
      reset_pin_oe_o <= (state == RSSEQ_OSC_WAIT) | (state == RSSEQ_PIN_LOW);
      // internal reset through whole sequence and pin low
      internal_reset_o <= (state == RSSEQ_OSC_WAIT) | (state == RSSEQ_PIN_LOW) |
                          (state == RSSEQ_INTERNAL_RESET_HOLD) | ext_hold;
      reset_vector_o <= monitor_mode_i ? RSSEQ_VEC_MON : RSSEQ_VEC_USER;
      cpu_clk_en_o <= run & ~wait_exec_i & ~ext_hold;
      mod_clk_en_o <= (state == RSSEQ_RUN) | (state == RSSEQ_INTERNAL_RESET_HOLD) |
                      (state == RSSEQ_PIN_LOW);
    end
  end
endmodule
`default_nettype wire

// ---- shared/rsseq_pkg.sv ----
// constants for the reset and stop-recovery sequencer
package rsseq_pkg;
  // timing in osc_ref_clock cycles (one enable pulse each)
  localparam int unsigned RSSEQ_POR_CYC = 4096;
  localparam int unsigned RSSEQ_PIN_CYC = 32;
  localparam int unsigned RSSEQ_INTERNAL_RESET_CYC = 32;
  localparam int unsigned RSSEQ_REL_CYC = 64;
  localparam int unsigned RSSEQ_STOP_LONG = 4096;
  localparam int unsigned RSSEQ_STOP_SHORT = 32;
  localparam int unsigned RSSEQ_PIN_MIN = 67;
  localparam int unsigned RSSEQ_PIN_MIN_POR = 4163;
  // counter geometry
  localparam int RSSEQ_CNT_W = 13;
  localparam int RSSEQ_SVC_LO = 4;
  localparam int RSSEQ_WD_W = 8;
  // cpu address facts
  localparam logic [15:0] RSSEQ_WD_SVC_ADDR = 16'hFFFF;
  localparam logic [15:0] RSSEQ_VEC_USER = 16'hFFFE;
  localparam logic [15:0] RSSEQ_VEC_MON = 16'hFEFE;
  localparam logic [15:0] RSSEQ_CAUSE_ADDR = 16'hFE01;
  // cause register bit positions
  localparam int RSSEQ_B_POR = 7;
  localparam int RSSEQ_B_PIN = 6;
  localparam int RSSEQ_B_WD = 5;
  localparam int RSSEQ_B_OP = 4;
  localparam int RSSEQ_B_AD = 3;
  localparam int RSSEQ_B_LV = 1;
  localparam logic [7:0] RSSEQ_CAUSE_RST = 8'h80;
  typedef enum logic [2:0] {
    RSSEQ_RUN, RSSEQ_OSC_WAIT, RSSEQ_PIN_LOW, RSSEQ_INTERNAL_RESET_HOLD, RSSEQ_STOPPED, RSSEQ_STOP_REC
  } rsseq_state_t;
endpackage

// ---- tb/rsseq_chk_assertions.sv ----
// port assertions for the reset and stop-recovery sequencer
`timescale 1ns/1ps
`default_nettype none
module rsseq_chk
  import rsseq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_o,
  input wire logic internal_reset_o,
  input wire logic cpu_clk_en_o,
  input wire logic bad_opcode_i,
  input wire logic monitor_mode_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] rdata_o,
  input wire logic [15:0] reset_vector_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  pin_od_a: assert property (reset_pin_o == 1'h0)
    else $error("reset pin driven high");
  cpu_off_a: assert property (internal_reset_o && $past(internal_reset_o) |-> !cpu_clk_en_o)
    else $error("cpu clock running in reset");
  rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data without strobe");
  cause_bits_a: assert property (rd_i && addr_i == RSSEQ_CAUSE_ADDR |=>
    rdata_o[7] && !rdata_o[2] && !rdata_o[0])
    else $error("cause register layout wrong");
  rd_other_a: assert property (rd_i && addr_i != RSSEQ_CAUSE_ADDR |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  vec_sel_a: assert property ($stable(monitor_mode_i)[*3] |->
    reset_vector_o == (monitor_mode_i ? RSSEQ_VEC_MON : RSSEQ_VEC_USER))
    else $error("reset vector wrong for mode");
  bad_op_a: assert property (bad_opcode_i && !internal_reset_o |-> ##[1:3] reset_pin_oe_o)
    else $error("bad opcode did not start reset");
  internal_reset_tail_a: assert property ($fell(reset_pin_oe_o) |-> internal_reset_o[*8])
    else $error("internal reset ended with pin");
  op_seen_c: cover property (bad_opcode_i ##[1:3] reset_pin_oe_o);
  tail_c: cover property ($fell(reset_pin_oe_o));
  cause_rd_c: cover property (rd_i && addr_i == RSSEQ_CAUSE_ADDR);
endmodule
bind rsseq_top rsseq_chk u_chk (.*);
`default_nettype wire

// ---- tb/rsseq_pin_model.sv ----
// board side: pulled-up reset line and free-running reference oscillator
`timescale 1ns/1ps
`default_nettype none
module rsseq_pin_model (
  input wire logic oe_i,
  input wire logic ext_low_i,
  output logic pin_n_o,
  output var logic osc_o
);
  // 90 ns period so ticks drift against the 20 ns bus clock
  initial osc_o = 1'h0;
  always #45 osc_o = ~osc_o;
  // board pulls line low on request
  // wired pull-up, low while anyone pulls
  assign pin_n_o = !(oe_i || ext_low_i);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the reset and stop-recovery sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rsseq_pkg::*;
;
  logic clk_i = 1'h0, rst_i = 1'h1, power_on_pulse_i = 1'h0, low_supply_i = 1'h0;
  logic wd_req_i = 1'h0, bad_opcode_i = 1'h0, stop_exec_i = 1'h0, wait_exec_i = 1'h0;
  logic stop_enable_i = 1'h0, short_stop_recovery_i = 1'h0, fetch_i = 1'h0, unmapped_i = 1'h0;
  logic wake_i = 1'h0, monitor_mode_i = 1'h0, break_state_i = 1'h0, hv_reset_pin_i = 1'h0;
  logic hv_irq_pin_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, ext_low = 1'h0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic [15:0] reset_vector_o;
  logic reset_pin_i, reset_pin_o, reset_pin_oe_o, internal_reset_o, cpu_clk_en_o, mod_clk_en_o;
  logic osc_ref_clock_i;
  int n_fail = 0, total_checks = 0, cyc = 0, n_oe = 0, n_ir = 0;

  rsseq_top dut (.*);
  rsseq_pin_model board (.oe_i(reset_pin_oe_o), .ext_low_i(ext_low), .pin_n_o(reset_pin_i),
    .osc_o(osc_ref_clock_i));

  always #10 clk_i = ~clk_i;
  // hang guard: two long resets at about five bus cycles a tick fit well inside
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      finish_test();
    end
  end
  // reference ticks with the pin pulled, then with internal reset alone
  always @(negedge osc_ref_clock_i) begin
    if (reset_pin_oe_o) n_oe++;
    else if (internal_reset_o) n_ir++;
  end

  task finish_test();
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // tick counts carry a few ticks of synchroniser slack
  task chkn(input string nm, input int e, input int g);
    total_checks++;
    if (g < e - 3 || g > e + 3) begin
      n_fail++;
      $display("[ERR] %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1 chk("rdata", {8'h00, e}, {8'h00, rdata_o});
  endtask
  task idle();
    int k;
    k = 0;
    while (internal_reset_o !== 1'h0 && k < 30000) begin
      @(posedge clk_i);
      k++;
    end
    chk("internal_reset_done", 16'h0000, {15'h0000, internal_reset_o});
  endtask
  // caller raises a source; held ten cycles so async sources pass their synchronisers
  task seq(input int e, input logic [7:0] f);
    n_oe = 0;
    n_ir = 0;
    repeat (10) @(posedge clk_i);
    bad_opcode_i <= 1'h0;
    stop_exec_i <= 1'h0;
    fetch_i <= 1'h0;
    unmapped_i <= 1'h0;
    low_supply_i <= 1'h0;
    wd_req_i <= 1'h0;
    idle();
    chkn("pin_ticks", e, n_oe);
    chkn("internal_reset_ticks", RSSEQ_INTERNAL_RESET_CYC, n_ir);
    rdc(RSSEQ_CAUSE_ADDR, f);
  endtask

  initial begin
    int k;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    seq(RSSEQ_POR_CYC + RSSEQ_PIN_CYC, RSSEQ_CAUSE_RST);
    chk("vector", RSSEQ_VEC_USER, reset_vector_o);
    bad_opcode_i <= 1'h1;
    seq(RSSEQ_PIN_CYC, 8'h90);
    unmapped_i <= 1'h1;
    repeat (20) @(posedge clk_i);
    chk("data_unmapped", 16'h0000, {15'h0000, internal_reset_o});
    fetch_i <= 1'h1;
    seq(RSSEQ_PIN_CYC, 8'h98);
    // service write, then a write to the read-only cause address
    @(posedge clk_i);
    wr_i <= 1'h1;
    addr_i <= RSSEQ_WD_SVC_ADDR;
    @(posedge clk_i);
    addr_i <= RSSEQ_CAUSE_ADDR;
    wdata_i <= 8'hFF;
    @(posedge clk_i);
    wr_i <= 1'h0;
    rdc(RSSEQ_CAUSE_ADDR, 8'h98);
    rdc(16'h0000, 8'h00);
    ext_low <= 1'h1;
    repeat (400) @(posedge clk_i);
    chk("pin_halt", 16'h0001, {15'h0000, internal_reset_o});
    ext_low <= 1'h0;
    idle();
    rdc(RSSEQ_CAUSE_ADDR, 8'hD8);
    stop_exec_i <= 1'h1;
    seq(RSSEQ_PIN_CYC, 8'hD8);
    stop_enable_i <= 1'h1;
    short_stop_recovery_i <= 1'h1;
    stop_exec_i <= 1'h1;
    @(posedge clk_i);
    stop_exec_i <= 1'h0;
    repeat (20) @(posedge clk_i);
    chk("cpu_stopped", 16'h0000, {15'h0000, cpu_clk_en_o});
    wake_i <= 1'h1;
    @(posedge clk_i);
    wake_i <= 1'h0;
    k = 0;
    while (cpu_clk_en_o !== 1'h1 && k < 500) begin
      @(negedge osc_ref_clock_i);
      k++;
    end
    chkn("stop_ticks", RSSEQ_STOP_SHORT, k);
    @(posedge clk_i);
    low_supply_i <= 1'h1;
    seq(RSSEQ_POR_CYC + RSSEQ_PIN_CYC, 8'hDA);
    wd_req_i <= 1'h1;
    seq(RSSEQ_PIN_CYC, 8'hFA);
    monitor_mode_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    chk("vector", RSSEQ_VEC_MON, reset_vector_o);
    finish_test();
  end
endmodule
`default_nettype wire
